// ---- verilog/dtc_defines.svh ----
// register offsets, field positions and timing counts for the dual timer/event counter
// assumes inclusion by bare name from the top module and the test files
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH
`define DTC_OFF_CNT0 12'h000
`define DTC_OFF_CNT1_LO 12'h004
`define DTC_OFF_CNT1_HI 12'h008
`define DTC_OFF_CTRL0 12'h00C
`define DTC_OFF_CTRL1 12'h010
`define DTC_OFF_IRQ_CTRL 12'h014
`define DTC_OFF_STATUS 12'h018
`define DTC_MODE_HI 7
`define DTC_MODE_LO 6
`define DTC_RUN_BIT 4
`define DTC_EDGE_BIT 3
`define DTC_COSEL_BIT 5
`define DTC_PSC_HI 2
`define DTC_PSC_LO 0
`define DTC_IE0_BIT 0
`define DTC_IE1_BIT 1
`define DTC_CNT1_DIV 4
`define DTC_CTRL_RESET 8'h00
`endif

// ---- verilog/dtc_pkg.sv ----
// types shared by the dual timer/event counter modules
// assumes dtc_defines.svh is on the include path
package dtc_pkg;
   typedef enum logic [1:0] {
      DTC_MODE_CMP = 2'b00,
      DTC_MODE_EVENT = 2'b01,
      DTC_MODE_TIMER = 2'b10,
      DTC_MODE_PULSE = 2'b11
   } dtc_mode_t;
   typedef enum logic [2:0] {
      DTC_PW_IDLE = 3'b001,
      DTC_PW_ARMED = 3'b010,
      DTC_PW_COUNT = 3'b100
   } dtc_pw_state_t;
endpackage

// ---- verilog/dtc_sync.sv ----
// two flip-flop synchroniser for asynchronous pin and comparator levels
// assumes a single clock domain and synchronous reset
`timescale 1ns/1ps
module dtc_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ---- verilog/dtc_tick.sv ----
// one-cycle tick generator: free-running divider, tick on the falling half of the derived clock
// assumes ratio is a power of two, at least 2
`timescale 1ns/1ps
module dtc_tick #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] ratio_m1,
   output logic tick
);
   logic [W-1:0] div_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         div_q <= '0;
      end else if (div_q >= ratio_m1) begin
         div_q <= '0;
      end else begin
         div_q <= W'(div_q + 1'b1);
      end
   end
   // the derived clock is high in the upper half of the count; wrapping is its falling edge
   assign tick = (div_q >= ratio_m1);
endmodule

// ---- verilog/dtc_top.sv ----
// dual timer/event counter: 8-bit counter 0 with prescaler, 16-bit counter 1 with byte buffering
// assumes an APB master on clk, asynchronous pin/comparator inputs, interrupt controller outside
// Operation
// - timer and pulse width modes count from the system clock
// - counter 0 internal clock passes a prescaler set by control bits 2..0
// - event mode counts one per qualifying pin, comparator or amplifier edge
// - mode bits plus compare output select bit choose comparator or amplifier source
// - count up to all ones, then overflow and request an interrupt
// - on overflow reload from preload and keep counting
// - writes to preload while stopped also load the counter
// - writes while running change only preload, used at next overflow
// - preload registers are not reset by hardware
// - low byte write of counter 1 goes into a buffer only
// - high byte write loads high byte and moves buffered low byte
// - high byte read latches low byte; low byte read returns latch
// - control bits 7..6 select comparator, event, timer or pulse width mode
// - run bit 4 lets the counter advance; cleared halts it
// - prescaler ignored for pin or comparator sources
// - edge select bit 3 picks active edge in event and pulse modes
// - counter 1 timer clock is system clock divided by four, no prescaler
// - timer mode advances on each falling edge of its timer clock
// - overflow interrupt wakes the device unless its enable bit is clear
// - edge select clear counts rising edges, set counts falling edges
// - pulse width counts between edges, then clears run and ignores edges
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`include "dtc_defines.svh"
module dtc_top #(
   parameter int W0 = 8,
   parameter int W1 = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic counter0_value_or_pin,
   input wire logic counter1_input_pin,
   input wire logic comparator_out,
   input wire logic amplifier1_out,
   output logic counter0_irq,
   output logic counter1_irq,
   output logic wake_request
);
   import dtc_pkg::*;

   logic [7:0] ctrl0_q, ctrl1_q;
   logic [1:0] irq_en_q;
   logic [W0-1:0] cnt0_q, pre0_q;
   logic [W1-1:0] cnt1_q, pre1_q;
   logic [7:0] lo_buf_q;
   logic [1:0] ovf_seen_q;
   logic [2:0] pins_s;
   logic [2:0] pins_q;
   logic tick0_int, tick1_int;
   dtc_pw_state_t pw0_q, pw1_q;

   function automatic dtc_mode_t mode_of(input logic [7:0] c);
      return dtc_mode_t'(c[`DTC_MODE_HI:`DTC_MODE_LO]);
   endfunction

   // true when the level change from old to new is the active edge for edge select e
   function automatic logic edge_hit(input logic old_l, input logic new_l, input logic e);
      return e ? (old_l & ~new_l) : (~old_l & new_l);
   endfunction

   // control field decodes, shared by both counters except the prescaler, used by counter 0 only
   function automatic logic run_of(input logic [7:0] c);
      return c[`DTC_RUN_BIT];
   endfunction

   function automatic logic edge_of(input logic [7:0] c);
      return c[`DTC_EDGE_BIT];
   endfunction

   function automatic logic cosel_of(input logic [7:0] c);
      return c[`DTC_COSEL_BIT];
   endfunction

   function automatic logic [2:0] psc_of(input logic [7:0] c);
      return c[`DTC_PSC_HI:`DTC_PSC_LO];
   endfunction

   // apb decode
   wire wr_en = psel & penable & pwrite;
   wire lane0 = pstrb[0];
   wire hit_any = (paddr == `DTC_OFF_CNT0) || (paddr == `DTC_OFF_CNT1_LO) ||
                  (paddr == `DTC_OFF_CNT1_HI) || (paddr == `DTC_OFF_CTRL0) ||
                  (paddr == `DTC_OFF_CTRL1) || (paddr == `DTC_OFF_IRQ_CTRL) ||
                  (paddr == `DTC_OFF_STATUS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   wire wr_cnt0 = wr_en & lane0 & (paddr == `DTC_OFF_CNT0);
   wire wr_lo = wr_en & lane0 & (paddr == `DTC_OFF_CNT1_LO);
   wire wr_hi = wr_en & lane0 & (paddr == `DTC_OFF_CNT1_HI);
   wire wr_c0 = wr_en & lane0 & (paddr == `DTC_OFF_CTRL0);
   wire wr_c1 = wr_en & lane0 & (paddr == `DTC_OFF_CTRL1);
   wire wr_ie = wr_en & lane0 & (paddr == `DTC_OFF_IRQ_CTRL);
   wire wr_st = wr_en & lane0 & (paddr == `DTC_OFF_STATUS);
   // the low byte is latched in the setup cycle, the cycle that also captures the high byte,
   // so a carry between setup and access cannot tear the pair
   wire rd_setup = psel & ~penable & ~pwrite;
   wire rd_hi = rd_setup & (paddr == `DTC_OFF_CNT1_HI);

   // pin and comparator levels are asynchronous
   dtc_sync #(.W(3)) u_sync (
      .clk(clk),
      .srst(srst),
      .async_in({amplifier1_out, comparator_out, counter0_value_or_pin}),
      .sync_out(pins_s)
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         pins_q <= '0;
      end else begin
         pins_q <= pins_s;
      end
   end

   // counter 0 timer tick, prescaled
   // the divider runs free, so the first timer period after start may be short
   dtc_tick #(.W(8)) u_psc0 (
      .clk(clk),
      .srst(srst),
      .ratio_m1(8'((9'h002 << psc_of(ctrl0_q)) - 9'h001)),
      .tick(tick0_int)
   );

   // counter 1 timer tick, fixed divide by four
   dtc_tick #(.W(2)) u_div1 (
      .clk(clk),
      .srst(srst),
      .ratio_m1(2'(`DTC_CNT1_DIV - 1)),
      .tick(tick1_int)
   );

   // counter 0 event source: comparator/amplifier in mode 00, pin in mode 01
   logic src0_old, src0_new;
   always_comb begin
      if (mode_of(ctrl0_q) == DTC_MODE_CMP) begin
         src0_old = cosel_of(ctrl1_q) ? pins_q[2] : pins_q[1];
         src0_new = cosel_of(ctrl1_q) ? pins_s[2] : pins_s[1];
      end else begin
         src0_old = pins_q[0];
         src0_new = pins_s[0];
      end
   end

   // counter 1 pin is synchronised separately from counter 0 inputs
   logic pin1_s;
   logic pin1_q;
   dtc_sync #(.W(1)) u_sync1 (
      .clk(clk),
      .srst(srst),
      .async_in(counter1_input_pin),
      .sync_out(pin1_s)
   );
   always_ff @(posedge clk) begin
      if (srst) begin
         pin1_q <= 1'b0;
      end else begin
         pin1_q <= pin1_s;
      end
   end

   // counter 1 mode 00 counts the selected comparator/amplifier source as well
   logic src1_old, src1_new;
   always_comb begin
      if (mode_of(ctrl1_q) == DTC_MODE_CMP) begin
         src1_old = cosel_of(ctrl1_q) ? pins_q[2] : pins_q[1];
         src1_new = cosel_of(ctrl1_q) ? pins_s[2] : pins_s[1];
      end else begin
         src1_old = pin1_q;
         src1_new = pin1_s;
      end
   end

   // advance strobes per mode; pulse width gating comes from the measuring state
   logic adv0, adv1;
   always_comb begin
      case (mode_of(ctrl0_q))
         DTC_MODE_CMP, DTC_MODE_EVENT: adv0 = edge_hit(src0_old, src0_new, ctrl0_q[`DTC_EDGE_BIT]);
         DTC_MODE_TIMER: adv0 = tick0_int;
         DTC_MODE_PULSE: adv0 = tick0_int & (pw0_q == DTC_PW_COUNT);
         default: adv0 = 1'b0;
      endcase
      adv0 = adv0 & run_of(ctrl0_q);
   end

   always_comb begin
      case (mode_of(ctrl1_q))
         DTC_MODE_CMP, DTC_MODE_EVENT: adv1 = edge_hit(src1_old, src1_new, ctrl1_q[`DTC_EDGE_BIT]);
         DTC_MODE_TIMER: adv1 = tick1_int;
         DTC_MODE_PULSE: adv1 = tick1_int & (pw1_q == DTC_PW_COUNT);
         default: adv1 = 1'b0;
      endcase
      adv1 = adv1 & run_of(ctrl1_q);
   end

   wire ovf0 = adv0 & (&cnt0_q);
   wire ovf1 = adv1 & (&cnt1_q);

   // pulse width: armed waits for the leading edge, count runs until the level returns
   // edge select clear measures a low pulse: start on the fall, stop when the pin rises again
   wire pw0_start = edge_hit(pins_q[0], pins_s[0], ~edge_of(ctrl0_q));
   wire pw0_stop = edge_hit(pins_q[0], pins_s[0], edge_of(ctrl0_q));
   wire pw1_start = edge_hit(pin1_q, pin1_s, ~edge_of(ctrl1_q));
   wire pw1_stop = edge_hit(pin1_q, pin1_s, edge_of(ctrl1_q));
   wire pw0_on = run_of(ctrl0_q) & (mode_of(ctrl0_q) == DTC_MODE_PULSE);
   wire pw1_on = run_of(ctrl1_q) & (mode_of(ctrl1_q) == DTC_MODE_PULSE);
   wire pw0_done = (pw0_q == DTC_PW_COUNT) & pw0_stop;
   wire pw1_done = (pw1_q == DTC_PW_COUNT) & pw1_stop;

   always_ff @(posedge clk) begin
      if (srst) begin
         pw0_q <= DTC_PW_IDLE;
      end else begin
         case (pw0_q)
            DTC_PW_IDLE: pw0_q <= pw0_on ? DTC_PW_ARMED : DTC_PW_IDLE;
            DTC_PW_ARMED: pw0_q <= !pw0_on ? DTC_PW_IDLE : (pw0_start ? DTC_PW_COUNT : DTC_PW_ARMED);
            DTC_PW_COUNT: pw0_q <= (!pw0_on || pw0_stop) ? DTC_PW_IDLE : DTC_PW_COUNT;
            default: pw0_q <= DTC_PW_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pw1_q <= DTC_PW_IDLE;
      end else begin
         case (pw1_q)
            DTC_PW_IDLE: pw1_q <= pw1_on ? DTC_PW_ARMED : DTC_PW_IDLE;
            DTC_PW_ARMED: pw1_q <= !pw1_on ? DTC_PW_IDLE : (pw1_start ? DTC_PW_COUNT : DTC_PW_ARMED);
            DTC_PW_COUNT: pw1_q <= (!pw1_on || pw1_stop) ? DTC_PW_IDLE : DTC_PW_COUNT;
            default: pw1_q <= DTC_PW_IDLE;
         endcase
      end
   end

   // control registers; hardware clearing the run bit beats nothing, software write wins if same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl0_q <= `DTC_CTRL_RESET;
         ctrl1_q <= `DTC_CTRL_RESET;
         irq_en_q <= '0;
      end else begin
         if (wr_c0) begin
            ctrl0_q <= pwdata[7:0];
         end else if (pw0_done) begin
            ctrl0_q[`DTC_RUN_BIT] <= 1'b0;
         end
         if (wr_c1) begin
            ctrl1_q <= pwdata[7:0];
         end else if (pw1_done) begin
            ctrl1_q[`DTC_RUN_BIT] <= 1'b0;
         end
         if (wr_ie) begin
            irq_en_q <= {pwdata[`DTC_IE1_BIT], pwdata[`DTC_IE0_BIT]};
         end
      end
   end

   // preloads have no reset: contents undefined until software writes them
   always_ff @(posedge clk) begin
      if (wr_cnt0) begin
         pre0_q <= W0'(pwdata[7:0]);
      end
      if (wr_lo) begin
         lo_buf_q <= pwdata[7:0];
      end else if (rd_hi) begin
         lo_buf_q <= cnt1_q[7:0];
      end
      if (wr_hi) begin
         pre1_q <= {pwdata[7:0], lo_buf_q};
      end
   end

   // counter values; also unreset, loaded only by preload path
   always_ff @(posedge clk) begin
      if (wr_cnt0 && !ctrl0_q[`DTC_RUN_BIT]) begin
         cnt0_q <= W0'(pwdata[7:0]);
      end else if (ovf0) begin
         cnt0_q <= pre0_q;
      end else if (adv0) begin
         cnt0_q <= W0'(cnt0_q + 1'b1);
      end
      if (wr_hi && !ctrl1_q[`DTC_RUN_BIT]) begin
         cnt1_q <= {pwdata[7:0], lo_buf_q};
      end else if (ovf1) begin
         cnt1_q <= pre1_q;
      end else if (adv1) begin
         cnt1_q <= W1'(cnt1_q + 1'b1);
      end
   end

   // overflow strobes, gated by the enables; sticky seen bits cleared by status write
   // wake follows the gated strobes, so a masked overflow neither interrupts nor wakes
   wire irq0_d = ovf0 & irq_en_q[`DTC_IE0_BIT];
   wire irq1_d = ovf1 & irq_en_q[`DTC_IE1_BIT];
   always_ff @(posedge clk) begin
      if (srst) begin
         counter0_irq <= 1'b0;
         counter1_irq <= 1'b0;
         wake_request <= 1'b0;
         ovf_seen_q <= '0;
      end else begin
         counter0_irq <= irq0_d;
         counter1_irq <= irq1_d;
         wake_request <= irq0_d | irq1_d;
         // set wins over a write-one clear in the same cycle
         ovf_seen_q <= (ovf_seen_q & ~(wr_st ? pwdata[1:0] : 2'b00)) | {ovf1, ovf0};
      end
   end

   // read mux; reads of the low byte return the latch, not the live count
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= '0;
      // captured in setup so the data already stands in the access cycle
      end else if (rd_setup) begin
         case (paddr)
            `DTC_OFF_CNT0: prdata <= 32'(cnt0_q);
            `DTC_OFF_CNT1_LO: prdata <= 32'(lo_buf_q);
            `DTC_OFF_CNT1_HI: prdata <= 32'(cnt1_q[15:8]);
            `DTC_OFF_CTRL0: prdata <= 32'(ctrl0_q);
            `DTC_OFF_CTRL1: prdata <= 32'(ctrl1_q);
            `DTC_OFF_IRQ_CTRL: prdata <= 32'(irq_en_q);
            `DTC_OFF_STATUS: prdata <= 32'(ovf_seen_q);
            default: prdata <= 32'h00000000;
         endcase
      end
   end
endmodule

// ---- test/dtc_pins.sv ----
// far-side model: counter pins, comparator and amplifier levels
// assumes calls come right after a rising clock edge
`timescale 1ns/1ps
module dtc_pins (
   input wire logic clk,
   output logic [3:0] line
);
   initial line = 4'h0;
   // six clocks per level so the two-stage synchroniser never misses one
   task automatic flip(input int s, input int k);
      for (int i = 0; i < k; i++) begin
         line[s] <= ~line[s];
         repeat (6) @(posedge clk);
      end
   endtask
   task automatic pulse(input int w);
      line[0] <= 1'b1;
      repeat (w) @(posedge clk);
      line[0] <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
endmodule

// ---- test/dtc_top_props.sv ----
// checker on the ports of the dual timer/event counter
// assumes a zero-wait bus and registered interrupt pulses
`timescale 1ns/1ps
`include "dtc_defines.svh"
module dtc_top_props (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic counter0_irq,
   input wire logic counter1_irq,
   input wire logic wake_request
);
   logic run0_q;
   logic ie0_q;
   wire wr = psel && penable && pwrite && pstrb[0];
   always_ff @(posedge clk) begin
      if (srst) begin
         run0_q <= 1'b0;
         ie0_q <= 1'b0;
      end else if (wr && paddr == `DTC_OFF_CTRL0) begin
         run0_q <= pwdata[`DTC_RUN_BIT];
      end else if (wr && paddr == `DTC_OFF_IRQ_CTRL) begin
         ie0_q <= pwdata[`DTC_IE0_BIT];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence wr_cnt0_off;
      wr && paddr == `DTC_OFF_CNT0 && !run0_q;
   endsequence
   sequence rd_cnt0_setup;
      psel && !penable && !pwrite && paddr == `DTC_OFF_CNT0;
   endsequence
   off_write_load_a: assert property (wr_cnt0_off ##2 rd_cnt0_setup |=> prdata[7:0] == $past(pwdata[7:0], 3))
      else $error("stopped counter write not loaded");
   irq0_pulse_a: assert property (counter0_irq |=> !counter0_irq)
      else $error("counter0 irq longer than one cycle");
   irq1_pulse_a: assert property (counter1_irq |=> !counter1_irq)
      else $error("counter1 irq longer than one cycle");
   wake_follows_a: assert property ((counter0_irq || counter1_irq) |-> ##[0:1] wake_request)
      else $error("irq without wake");
   wake_cause_a: assert property (wake_request |-> counter0_irq || counter1_irq || $past(counter0_irq || counter1_irq))
      else $error("wake without irq");
   irq_masked_a: assert property (!ie0_q && !$past(ie0_q) && !$past(ie0_q, 2) |-> !counter0_irq)
      else $error("masked counter0 irq raised");
   ready_now_a: assert property (psel && penable |-> pready)
      else $error("access phase not ready");
   err_access_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   rdata_byte_a: assert property (prdata[31:8] == 24'h0)
      else $error("upper read bits set");
endmodule
bind dtc_top dtc_top_props u_props (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
   .pready, .pslverr, .counter0_irq, .counter1_irq, .wake_request);

// ---- test/tb_dtc_top.sv ----
// self-checking bench for the dual timer/event counter
// assumes dtc_defines.svh on the include path
`timescale 1ns/1ps
`include "dtc_defines.svh"
module tb_dtc_top;
   import dtc_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] line;
   logic [1:0] irq;
   logic wake;
   logic [31:0] rv;
   logic ev;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int nirq = 0;
   int c;
   always #25 clk = ~clk;
   dtc_top dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .counter0_value_or_pin(line[0]), .counter1_input_pin(line[1]), .comparator_out(line[2]),
      .amplifier1_out(line[3]), .counter0_irq(irq[0]), .counter1_irq(irq[1]), .wake_request(wake));
   dtc_pins pm (.clk, .line);
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (irq[0] === 1'b1) nirq <= nirq + 1;
      if (cycles == 30000) begin
         err_count++;
         complete_run();
      end
   end
   task automatic complete_run();
      if (err_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] cw(input dtc_mode_t m, input logic r, input logic e, input logic [2:0] p);
      return {m, 1'b0, r, e, p};
   endfunction
   // one idle cycle between transfers keeps each strobe to one assignment per step
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= 4'hF;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd1();
      logic [7:0] h;
      apb(0, `DTC_OFF_CNT1_HI, 8'h00);
      h = rv[7:0];
      apb(0, `DTC_OFF_CNT1_LO, 8'h00);
      rv = {16'h0, h, rv[7:0]};
   endtask
   task automatic gap(input int w);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (irq[w] !== 1'b1);
   endtask
   task automatic t_stopped();
      apb(0, `DTC_OFF_CTRL1, 8'h00);
      chk(rv, 32'h0);
      apb(1, `DTC_OFF_CTRL0, cw(DTC_MODE_TIMER, 0, 0, 3'h0));
      apb(1, `DTC_OFF_CNT0, 8'h5A);
      apb(0, `DTC_OFF_CNT0, 8'h00);
      chk(rv, 32'h5A);
      repeat (20) @(posedge clk);
      apb(0, `DTC_OFF_CNT0, 8'h00);
      chk(rv, 32'h5A);
      apb(0, 12'h01C, 8'h00);
      chk({rv[30:0], ev}, 32'h1);
   endtask
   task automatic t_timer0();
      apb(1, `DTC_OFF_IRQ_CTRL, 8'h03);
      for (int n = 0; n < 8; n++) begin
         apb(1, `DTC_OFF_CTRL0, 8'h00);
         apb(1, `DTC_OFF_CNT0, 8'hFE);
         apb(1, `DTC_OFF_CTRL0, cw(DTC_MODE_TIMER, 1, 0, n[2:0]));
         repeat (2) gap(0);
         chk(c, 2 << (n + 1));
      end
      // the second gap is the first one sure to start from the new preload
      apb(1, `DTC_OFF_CNT0, 8'hF0);
      repeat (3) gap(0);
      chk(c, 32'h1000);
      apb(1, `DTC_OFF_IRQ_CTRL, 8'h02);
      // restart at the fastest rate so the masked window holds many overflows
      apb(1, `DTC_OFF_CTRL0, 8'h00);
      apb(1, `DTC_OFF_CNT0, 8'hFE);
      apb(1, `DTC_OFF_CTRL0, cw(DTC_MODE_TIMER, 1, 0, 3'h0));
      c = nirq;
      repeat (100) @(posedge clk);
      chk(nirq - c, 0);
      apb(1, `DTC_OFF_CTRL0, 8'h00);
      apb(0, `DTC_OFF_STATUS, 8'h00);
      chk(rv[0], 1);
      apb(1, `DTC_OFF_STATUS, 8'h03);
      apb(0, `DTC_OFF_STATUS, 8'h00);
      chk(rv, 0);
   endtask
   task automatic t_cnt1();
      apb(1, `DTC_OFF_CTRL1, 8'h00);
      apb(1, `DTC_OFF_CNT1_LO, 8'h34);
      apb(1, `DTC_OFF_CNT1_HI, 8'h12);
      apb(1, `DTC_OFF_CNT1_LO, 8'h56);
      rd1();
      chk(rv, 32'h1234);
      apb(1, `DTC_OFF_CNT1_LO, 8'h78);
      apb(1, `DTC_OFF_CNT1_HI, 8'hAB);
      rd1();
      chk(rv, 32'hAB78);
      apb(1, `DTC_OFF_CNT1_LO, 8'hFE);
      apb(1, `DTC_OFF_CNT1_HI, 8'hFF);
      apb(1, `DTC_OFF_CTRL1, cw(DTC_MODE_TIMER, 1, 0, 3'h0));
      repeat (2) gap(1);
      chk(c, 8);
      apb(1, `DTC_OFF_CTRL1, 8'h00);
   endtask
   task automatic t_events();
      logic lv;
      for (int s = 0; s < 4; s++) begin
         for (int e = 0; e < 2; e++) begin
            apb(1, `DTC_OFF_CTRL0, 8'h00);
            apb(1, `DTC_OFF_CTRL1, (s == 3) ? 8'h20 : 8'h00);
            apb(1, `DTC_OFF_CNT0, 8'h00);
            apb(1, `DTC_OFF_CNT1_LO, 8'h00);
            apb(1, `DTC_OFF_CNT1_HI, 8'h00);
            if (s == 1) apb(1, `DTC_OFF_CTRL1, cw(DTC_MODE_EVENT, 1, e[0], 3'h0));
            else apb(1, `DTC_OFF_CTRL0, cw((s == 0) ? DTC_MODE_EVENT : DTC_MODE_CMP, 1, e[0], 3'h7));
            pm.flip(s ^ 1, 3);
            lv = line[s];
            pm.flip(s, 5);
            if (s == 1) rd1();
            else apb(0, `DTC_OFF_CNT0, 8'h00);
            chk(rv, (e[0] ^ lv) ? 32'h2 : 32'h3);
         end
      end
   endtask
   task automatic t_pulse();
      logic [31:0] q;
      apb(1, `DTC_OFF_CTRL1, 8'h00);
      apb(1, `DTC_OFF_CTRL0, 8'h00);
      apb(1, `DTC_OFF_CNT0, 8'h00);
      if (line[0]) pm.flip(0, 1);
      // edge select set measures a high pulse: start on the rise, stop on the fall
      apb(1, `DTC_OFF_CTRL0, cw(DTC_MODE_PULSE, 1, 1, 3'h0));
      pm.pulse(40);
      apb(0, `DTC_OFF_CNT0, 8'h00);
      q = rv;
      chk(q >= 19 && q <= 21, 1);
      apb(0, `DTC_OFF_CTRL0, 8'h00);
      chk(rv[`DTC_RUN_BIT], 0);
      pm.pulse(20);
      apb(0, `DTC_OFF_CNT0, 8'h00);
      chk(rv, q);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      t_stopped();
      t_timer0();
      t_cnt1();
      t_events();
      t_pulse();
      complete_run();
   end
endmodule
